/* logic/tsa_alert_core.sv */
`timescale 1ns/1ps
// ****************************************
// Limit check, fault counting, alert state
// ****************************************
module tsa_alert_core (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sample_stb,
  input tsa_pkg::tsa_word_type i_sample,
  input tsa_pkg::tsa_word_type i_upper,
  input tsa_pkg::tsa_word_type i_lower,
  input wire logic [1:0] i_faults,
  input wire logic i_evt_mode,
  input wire logic i_ack,
  output logic o_tripped,
  output logic o_event
);
  logic [1:0] cnt_q;
  logic cond;
  logic toggle;

  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction

  // Watch the limit that leads out of the present state
  always_comb
  begin
    cond = o_tripped ? sgt(i_lower, i_sample) : sgt(i_sample, i_upper);
    toggle = i_sample_stb && cond && (cnt_q >= i_faults);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      cnt_q <= 2'h0;
    else if (i_sample_stb)
    begin
      if (!cond || toggle)
        cnt_q <= 2'h0;
      else
        cnt_q <= cnt_q + 2'h1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_tripped <= 1'b0;
    else if (toggle)
      o_tripped <= ~o_tripped;
  end

  // A new crossing wins over a clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_event <= 1'b0;
    else if (toggle && i_evt_mode)
      o_event <= 1'b1;
    else if (i_ack || !i_evt_mode)
      o_event <= 1'b0;
  end
endmodule

/* logic/tsa_byte_pair.sv */
`timescale 1ns/1ps
// ****************************************
// MSB-first byte pairing for register access
// ****************************************
module tsa_byte_pair (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_xfer_start,
  input wire logic i_wr_stb,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_rd_stb,
  output logic o_wr_word_stb,
  output tsa_pkg::tsa_word_type o_wr_word,
  output logic o_rd_lsb
);
  logic phase_q;
  logic [7:0] msb_q;

  assign o_rd_lsb = phase_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || i_xfer_start)
      phase_q <= 1'b0;
    else if (i_wr_stb || i_rd_stb)
      phase_q <= ~phase_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      msb_q <= 8'h00;
    else if (i_wr_stb && !phase_q)
      msb_q <= i_wr_byte;
  end

  // Word commits one cycle after its second byte
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_wr_word_stb <= 1'b0;
      o_wr_word <= 16'h0000;
    end
    else
    begin
      o_wr_word_stb <= i_wr_stb && phase_q && !i_xfer_start;
      if (i_wr_stb && phase_q)
        o_wr_word <= {msb_q, i_wr_byte};
    end
  end
endmodule

/* logic/tsa_cfg.svh */
`ifndef TSA_CFG_SVH
`define TSA_CFG_SVH
`define TSA_IDX_RESULT 2'h0
`define TSA_IDX_SETTINGS 2'h1
`define TSA_IDX_LOWER 2'h2
`define TSA_IDX_UPPER 2'h3
`define TSA_AL_BIT 5
`define TSA_RATE_LSB 6
`define TSA_SLEEP_BIT 8
`define TSA_EVT_BIT 9
`define TSA_LVL_BIT 10
`define TSA_FAULT_LSB 11
`define TSA_ZERO_BIT 13
`define TSA_ONE_BIT 14
`define TSA_SHOT_BIT 15
`define TSA_RATE_RST 2'h2
`define TSA_LIMIT_MASK 16'hFFF0
`define TSA_LOWER_RST 16'h2580
`define TSA_UPPER_RST 16'h2800
`define TSA_RESULT_RST 16'h0000
`define TSA_CLK_KHZ 100000
`define TSA_CONV_MS 36
`define TSA_SLEEP_ENTRY_MS 120
`define TSA_PERIOD_MS_0 4000
`define TSA_PERIOD_MS_1 1000
`define TSA_PERIOD_MS_2 250
`define TSA_PERIOD_MS_3 125
`endif

/* logic/tsa_pkg.sv */
package tsa_pkg;
  typedef enum logic [1:0] {
    TSA_CONVERT,
    TSA_STANDBY,
    TSA_SLEEP
  } tsa_state_type;
  typedef logic [15:0] tsa_word_type;
endpackage

/* logic/tsa_sensor_core.sv */
`timescale 1ns/1ps
`include "tsa_cfg.svh"
// Notes on behaviour
// - Settings are 16 bits, moved most significant byte first.
// - Bits 0-4, 13, 14 ignore writes; bit 14 reads one, others zero.
// - With polarity clear, status bit reads one normally, zero in alarm.
// - Polarity also inverts the levels of the status bit.
// - In comparator mode status bit equals the alert pin level.
// - Rate field picks 0.25, 1, 4 or 8 conversions per second.
// - Rate field resets to binary 10, four per second.
// - Result changes only when a conversion completes.
// - First conversion starts at reset unprompted, result within 36 ms.
// - Between conversions the block waits in standby until period ends.
// - Setting sleep stops automatic conversions at once.
// - In sleep all registers stay readable; settings and limits stay writable.
// - First conversion after sleep entry takes the extra entry time.
// - Clearing sleep resumes automatic conversions at the set rate.
// - Mode bit: zero comparator, one interrupt.
// - Comparator alert sets above upper limit, clears below lower.
// - Interrupt alert fires on each crossing of either limit.
// - Polarity zero drives alert low when active, one drives high.
// - Fault-count field sets N as 1, 2, 3 or 4.
// - Alert changes after N consecutive faulting results; others restart.
// - Single-shot in sleep runs one conversion, bit reads one meanwhile.
// - Interrupt alert clears on any read or on writing sleep one.
// - Result and limits are 16-bit two's complement, 1/128 degree.
module tsa_sensor_core #(
  parameter logic [31:0] P_CONV_CYC = 32'(`TSA_CONV_MS * `TSA_CLK_KHZ),
  parameter logic [31:0] P_SLEEP_EXTRA_CYC =
    32'(`TSA_SLEEP_ENTRY_MS * `TSA_CLK_KHZ),
  parameter logic [31:0] P_PERIOD_CYC_0 =
    32'(`TSA_PERIOD_MS_0 * `TSA_CLK_KHZ),
  parameter logic [31:0] P_PERIOD_CYC_1 =
    32'(`TSA_PERIOD_MS_1 * `TSA_CLK_KHZ),
  parameter logic [31:0] P_PERIOD_CYC_2 =
    32'(`TSA_PERIOD_MS_2 * `TSA_CLK_KHZ),
  parameter logic [31:0] P_PERIOD_CYC_3 =
    32'(`TSA_PERIOD_MS_3 * `TSA_CLK_KHZ)
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_reg_index,
  input wire logic i_xfer_start,
  input wire logic i_wr_stb,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_rd_stb,
  output logic [7:0] o_rd_byte,
  input tsa_pkg::tsa_word_type i_adc_result,
  output logic o_conv_active,
  output logic o_sleeping,
  output logic o_alert
);
  // ****************************************
  // Declarations
  // ****************************************
  tsa_pkg::tsa_state_type state_q;
  tsa_pkg::tsa_state_type state_d;
  logic [1:0] rate_q;
  logic sleep_q;
  logic evt_mode_q;
  logic lvl_q;
  logic [1:0] faults_q;
  logic shot_q;
  tsa_pkg::tsa_word_type upper_q;
  tsa_pkg::tsa_word_type lower_q;
  tsa_pkg::tsa_word_type result_q;
  tsa_pkg::tsa_word_type snap_q;
  tsa_pkg::tsa_word_type cfg_word;
  tsa_pkg::tsa_word_type reg_word;
  tsa_pkg::tsa_word_type wr_word;
  logic [31:0] elapsed_q;
  logic [31:0] elapsed_inc;
  logic [31:0] conv_len_q;
  logic first_q;
  logic done_q;
  logic wr_word_stb;
  logic rd_lsb;
  logic wr_set;
  logic new_sleep;
  logic go_sleep;
  logic start_shot;
  logic launch;
  logic conv_end;
  logic period_end;
  logic conv_done_c;
  logic tripped;
  logic alarm_event;
  logic alarm_act;
  logic al_bit;

  function automatic logic [31:0] period_cyc(input logic [1:0] rate);
    case (rate)
      2'h0: period_cyc = P_PERIOD_CYC_0;
      2'h1: period_cyc = P_PERIOD_CYC_1;
      2'h2: period_cyc = P_PERIOD_CYC_2;
      default: period_cyc = P_PERIOD_CYC_3;
    endcase
  endfunction

  // ****************************************
  // Register access
  // ****************************************
  tsa_byte_pair u_pair (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_xfer_start(i_xfer_start),
    .i_wr_stb(i_wr_stb),
    .i_wr_byte(i_wr_byte),
    .i_rd_stb(i_rd_stb),
    .o_wr_word_stb(wr_word_stb),
    .o_wr_word(wr_word),
    .o_rd_lsb(rd_lsb)
  );

  assign wr_set = wr_word_stb && (i_reg_index == `TSA_IDX_SETTINGS);
  assign new_sleep = wr_word[`TSA_SLEEP_BIT];
  assign go_sleep = wr_set && new_sleep;
  // A shot is only honoured with sleep set in the same write
  assign start_shot = go_sleep && wr_word[`TSA_SHOT_BIT] && !shot_q;

  always_comb
  begin
    cfg_word = 16'h0000;
    cfg_word[`TSA_AL_BIT] = al_bit;
    cfg_word[`TSA_RATE_LSB+:2] = rate_q;
    cfg_word[`TSA_SLEEP_BIT] = sleep_q;
    cfg_word[`TSA_EVT_BIT] = evt_mode_q;
    cfg_word[`TSA_LVL_BIT] = lvl_q;
    cfg_word[`TSA_FAULT_LSB+:2] = faults_q;
    cfg_word[`TSA_ONE_BIT] = 1'b1;
    cfg_word[`TSA_SHOT_BIT] = shot_q;
  end

  always_comb
  begin
    case (i_reg_index)
      `TSA_IDX_RESULT: reg_word = result_q;
      `TSA_IDX_SETTINGS: reg_word = cfg_word;
      `TSA_IDX_LOWER: reg_word = lower_q;
      default: reg_word = upper_q;
    endcase
  end

  // Word is frozen at the first byte so both halves agree
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      snap_q <= 16'h0000;
      o_rd_byte <= 8'h00;
    end
    else if (i_rd_stb && !rd_lsb)
    begin
      snap_q <= reg_word;
      o_rd_byte <= reg_word[15:8];
    end
    else if (i_rd_stb)
      o_rd_byte <= snap_q[7:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rate_q <= `TSA_RATE_RST;
      sleep_q <= 1'b0;
      evt_mode_q <= 1'b0;
      lvl_q <= 1'b0;
      faults_q <= 2'h0;
    end
    else if (wr_set)
    begin
      rate_q <= wr_word[`TSA_RATE_LSB+:2];
      sleep_q <= new_sleep;
      evt_mode_q <= wr_word[`TSA_EVT_BIT];
      lvl_q <= wr_word[`TSA_LVL_BIT];
      faults_q <= wr_word[`TSA_FAULT_LSB+:2];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      lower_q <= `TSA_LOWER_RST;
      upper_q <= `TSA_UPPER_RST;
    end
    else if (wr_word_stb && i_reg_index == `TSA_IDX_LOWER)
      lower_q <= wr_word & `TSA_LIMIT_MASK;
    else if (wr_word_stb && i_reg_index == `TSA_IDX_UPPER)
      upper_q <= wr_word & `TSA_LIMIT_MASK;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      shot_q <= 1'b0;
    else if (start_shot)
      shot_q <= 1'b1;
    else if (conv_done_c)
      shot_q <= 1'b0;
  end

  // ****************************************
  // Conversion sequencing
  // ****************************************
  assign elapsed_inc = elapsed_q + 32'h00000001;
  assign conv_end = elapsed_inc >= conv_len_q;
  assign period_end = elapsed_inc >= period_cyc(rate_q);

  always_comb
  begin
    state_d = state_q;
    launch = 1'b0;
    conv_done_c = 1'b0;
    case (state_q)
      tsa_pkg::TSA_CONVERT:
      begin
        if (start_shot)
          launch = 1'b1;
        else if (go_sleep && !shot_q)
          state_d = tsa_pkg::TSA_SLEEP;
        else if (conv_end)
        begin
          conv_done_c = 1'b1;
          if (sleep_q)
            state_d = tsa_pkg::TSA_SLEEP;
          else
            state_d = tsa_pkg::TSA_STANDBY;
        end
      end
      tsa_pkg::TSA_STANDBY:
      begin
        if (start_shot)
        begin
          state_d = tsa_pkg::TSA_CONVERT;
          launch = 1'b1;
        end
        else if (go_sleep)
          state_d = tsa_pkg::TSA_SLEEP;
        else if (period_end)
        begin
          state_d = tsa_pkg::TSA_CONVERT;
          launch = 1'b1;
        end
      end
      tsa_pkg::TSA_SLEEP:
      begin
        if (start_shot || (wr_set && !new_sleep))
        begin
          state_d = tsa_pkg::TSA_CONVERT;
          launch = 1'b1;
        end
      end
      default:
      begin
        state_d = tsa_pkg::TSA_CONVERT;
        launch = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      state_q <= tsa_pkg::TSA_CONVERT;
    else
      state_q <= state_d;
  end

  // Elapsed time is measured from the start of each conversion
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || launch || state_q == tsa_pkg::TSA_SLEEP)
      elapsed_q <= 32'h00000000;
    else
      elapsed_q <= elapsed_inc;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      conv_len_q <= P_CONV_CYC;
    else if (launch && (first_q || go_sleep))
      conv_len_q <= P_CONV_CYC + P_SLEEP_EXTRA_CYC;
    else if (launch)
      conv_len_q <= P_CONV_CYC;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || launch)
      first_q <= 1'b0;
    else if (go_sleep)
      first_q <= 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      result_q <= `TSA_RESULT_RST;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= conv_done_c;
      if (conv_done_c)
        result_q <= i_adc_result;
    end
  end

  // ****************************************
  // Alert
  // ****************************************
  tsa_alert_core u_alert (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_sample_stb(done_q),
    .i_sample(result_q),
    .i_upper(upper_q),
    .i_lower(lower_q),
    .i_faults(faults_q),
    .i_evt_mode(evt_mode_q),
    .i_ack(i_rd_stb || go_sleep),
    .o_tripped(tripped),
    .o_event(alarm_event)
  );

  assign alarm_act = evt_mode_q ? alarm_event : tripped;
  // Comparator mode reads the pin back so both always agree
  assign al_bit = evt_mode_q ? (lvl_q ? tripped : !tripped)
                             : o_alert;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_alert <= 1'b1;
      o_conv_active <= 1'b0;
      o_sleeping <= 1'b0;
    end
    else
    begin
      o_alert <= lvl_q ? alarm_act : !alarm_act;
      o_conv_active <= state_d == tsa_pkg::TSA_CONVERT;
      o_sleeping <= state_d == tsa_pkg::TSA_SLEEP;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_cmp_steady;
    !evt_mode_q && $stable(lvl_q) && $stable(tripped);
  endsequence
  sequence s_shot_busy;
    shot_q && state_q == tsa_pkg::TSA_CONVERT;
  endsequence
  sequence s_shot_done;
    !shot_q && state_q == tsa_pkg::TSA_SLEEP;
  endsequence

  chk_fixed_bits: assert property (
    cfg_word[4:0] == 5'h00 && !cfg_word[`TSA_ZERO_BIT]
    && cfg_word[`TSA_ONE_BIT])
    else $error("settings fixed bits wrong");
  chk_rate_default: assert property (
    disable iff (1'b0) !i_rst_n |=> rate_q == `TSA_RATE_RST)
    else $error("rate not four per second after reset");
  chk_boot_convert: assert property (
    disable iff (1'b0) !i_rst_n ##1 i_rst_n
    |-> state_q == tsa_pkg::TSA_CONVERT && conv_len_q == P_CONV_CYC
    ##1 o_conv_active)
    else $error("no conversion started after reset");
  chk_result_hold: assert property (
    !conv_done_c |=> $stable(result_q))
    else $error("result changed between conversions");
  chk_sleep_stop: assert property (
    go_sleep && !start_shot && !shot_q
    |=> state_q == tsa_pkg::TSA_SLEEP && !o_conv_active)
    else $error("sleep did not stop conversions");
  chk_wake_resume: assert property (
    state_q == tsa_pkg::TSA_SLEEP && wr_set && !new_sleep
    |=> state_q == tsa_pkg::TSA_CONVERT && elapsed_q == 32'h00000000)
    else $error("clearing sleep did not resume");
  chk_shot_start: assert property (
    start_shot |=> s_shot_busy)
    else $error("single shot not running");
  chk_shot_end: assert property (
    shot_q && conv_done_c && sleep_q |=> s_shot_done)
    else $error("single shot did not end in sleep");
  chk_shot_ignored: assert property (
    wr_set && !new_sleep && !shot_q |=> !shot_q)
    else $error("single shot taken while awake");
  chk_int_clear: assert property (
    evt_mode_q && i_rd_stb && !done_q |=> !alarm_event)
    else $error("interrupt alert not cleared by read");
  chk_status_level: assert property (
    s_cmp_steady ##1 s_cmp_steady
    |-> al_bit == (lvl_q ? tripped : !tripped))
    else $error("status bit level wrong");
  chk_pin_level: assert property (
    s_cmp_steady ##1 s_cmp_steady
    |-> o_alert == (lvl_q ? tripped : !tripped))
    else $error("alert pin level wrong");
  chk_fault_cause: assert property (
    $changed(tripped) |-> $past(done_q))
    else $error("alert state changed without a result");
  chk_byte_order: assert property (
    i_rd_stb && !rd_lsb && !i_xfer_start
    |=> o_rd_byte == $past(reg_word[15:8]))
    else $error("first byte read is not the high byte");
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
// ****************************************
// Self-checking bench for the sensor core
// ****************************************
module testbench;
  localparam int CONV = 20;
  localparam int EXTRA = 10;
  localparam int PER [4] = '{200, 100, 60, 40};
  localparam logic [15:0] UP = 16'h0C80;
  localparam logic [15:0] LO = 16'hF380;
  logic clk;
  logic rst_n;
  logic [1:0] reg_index;
  logic xfer_start;
  logic wr_stb;
  logic [7:0] wr_byte;
  logic rd_stb;
  logic [7:0] rd_byte;
  tsa_pkg::tsa_word_type adc;
  logic conv_active;
  logic sleeping;
  logic alert;
  logic [15:0] lfsr;
  logic [15:0] w;
  logic [15:0] last_s;
  logic alarm_m;
  logic evt_m;
  logic pol_m;
  logic [1:0] nf_m;
  int cnt_m;
  int d;
  int n_fail;
  int n_checks;

  tsa_sensor_core #(
    .P_CONV_CYC(32'(CONV)),
    .P_SLEEP_EXTRA_CYC(32'(EXTRA)),
    .P_PERIOD_CYC_0(32'(PER[0])),
    .P_PERIOD_CYC_1(32'(PER[1])),
    .P_PERIOD_CYC_2(32'(PER[2])),
    .P_PERIOD_CYC_3(32'(PER[3]))
  ) DUT (
    .i_clk(clk),
    .i_rst_n(rst_n),
    .i_reg_index(reg_index),
    .i_xfer_start(xfer_start),
    .i_wr_stb(wr_stb),
    .i_wr_byte(wr_byte),
    .i_rd_stb(rd_stb),
    .o_rd_byte(rd_byte),
    .i_adc_result(adc),
    .o_conv_active(conv_active),
    .o_sleeping(sleeping),
    .o_alert(alert)
  );

  tsa_host_model host (
    .i_clk(clk),
    .i_rd_byte(rd_byte),
    .o_reg_index(reg_index),
    .o_xfer_start(xfer_start),
    .o_wr_stb(wr_stb),
    .o_wr_byte(wr_byte),
    .o_rd_stb(rd_stb)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] next_rand(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Pin or status level for an active or idle condition
  function automatic logic shown(input logic act);
    return act ? pol_m : !pol_m;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_conv(input logic lvl, output int n);
    n = 0;
    while (conv_active !== lvl)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 2000)
      begin
        n_fail++;
        stop_test();
      end
    end
  endtask

  task automatic period(output int p);
    int a;
    int b;
    // Skip to a clean conversion start, then time one run plus standby
    wait_conv(1'b0, a);
    wait_conv(1'b1, a);
    wait_conv(1'b0, a);
    wait_conv(1'b1, b);
    p = a + b;
    if (a != CONV)
      p = -1;
  endtask

  // One tracked conversion: feed a sample, update the alert model
  task automatic conv(input logic [15:0] s, input logic im);
    wait_conv(1'b1, d);
    @(posedge clk);
    adc <= s;
    host.read_word(2'h0, w);
    check(w, last_s);
    evt_m = 1'b0;
    wait_conv(1'b0, d);
    if (!alarm_m ? $signed(s) > $signed(UP) : $signed(s) < $signed(LO))
      cnt_m++;
    else
      cnt_m = 0;
    if (cnt_m == nf_m + 1)
    begin
      alarm_m = !alarm_m;
      cnt_m = 0;
      evt_m = im;
    end
    last_s = s;
    @(posedge clk);
    adc <= 16'h0000;
    repeat (2) @(posedge clk);
    #1;
    check(alert, shown(im ? evt_m : alarm_m));
  endtask

  initial
  begin
    n_fail = 0;
    n_checks = 0;
    rst_n = 1'b0;
    adc = 16'h0123;
    lfsr = 16'hEEEC;
    alarm_m = 1'b0;
    evt_m = 1'b0;
    pol_m = 1'b0;
    nf_m = 2'h0;
    cnt_m = 0;
    last_s = 16'h0000;
    repeat (8) @(posedge clk);
    #1;
    check(alert, 16'h1);
    check(conv_active, 16'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_conv(1'b1, d);
    check(16'(d < 3), 16'h1);
    host.read_word(2'h0, w);
    check(w, 16'h0000);
    wait_conv(1'b0, d);
    host.read_word(2'h0, w);
    check(w, 16'h0123);
    host.read_word(2'h1, w);
    check(w, 16'h40A0);
    host.read_word(2'h2, w);
    check(w, 16'h2580);
    host.read_word(2'h3, w);
    check(w, 16'h2800);
    @(posedge clk);
    adc <= 16'h0000;
    host.write_word(2'h1, 16'h60BF);
    host.read_word(2'h1, w);
    check(w, 16'h40A0);
    for (int r = 0; r < 4; r++)
    begin
      host.write_word(2'h1, 16'(r) << 6);
      period(d);
      check(16'(d), 16'(PER[r]));
    end
    host.write_word(2'h1, 16'h80C0);
    host.read_word(2'h1, w);
    check(w, 16'h40E0);
    wait_conv(1'b1, d);
    wait_conv(1'b0, d);
    host.write_word(2'h1, 16'h81C0);
    check(conv_active, 16'h1);
    wait_conv(1'b1, d);
    wait_conv(1'b0, d);
    check(16'(d >= CONV + EXTRA - 1 && d <= CONV + EXTRA), 16'h1);
    host.read_word(2'h1, w);
    check(w, 16'h41E0);
    d = 0;
    repeat (300)
    begin
      @(posedge clk);
      #1;
      if (conv_active !== 1'b0)
        d++;
    end
    check(16'(d), 16'h0);
    host.write_word(2'h3, UP);
    host.write_word(2'h2, LO | 16'h000F);
    host.read_word(2'h2, w);
    check(w, LO);
    host.write_word(2'h1, 16'h81C0);
    wait_conv(1'b1, d);
    host.read_word(2'h1, w);
    check(w, 16'hC1E0);
    wait_conv(1'b0, d);
    host.write_word(2'h1, 16'h00C0);
    check(sleeping, 16'h0);
    period(d);
    check(16'(d), 16'(PER[3]));
    // Every fault count, both polarities, both alert modes
    for (int i = 0; i < 8; i++)
    begin
      nf_m = i[1:0];
      pol_m = i[2];
      host.write_word(2'h1, {3'h0, nf_m, pol_m, i[0], 3'h3, 6'h00});
      conv(16'h0000, i[0]);
      repeat (10)
      begin
        lfsr = next_rand(lfsr);
        conv(lfsr[1:0] == 2'h0 ? 16'h0000 : alarm_m ?
          LO - {8'h00, lfsr[11:4]} - 16'h1 :
          UP + {8'h00, lfsr[11:4]} + 16'h1, i[0]);
      end
      host.read_word(2'h1, w);
      evt_m = 1'b0;
      check(w[5], shown(alarm_m));
      repeat (3) @(posedge clk);
      #1;
      check(alert, shown(i[0] ? 1'b0 : alarm_m));
    end
    stop_test();
  end
endmodule

/* verification/tsa_host_model.sv */
`timescale 1ns/1ps
// ****************************************
// Register bus master on the byte strobes
// ****************************************
module tsa_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rd_byte,
  output logic [1:0] o_reg_index,
  output logic o_xfer_start,
  output logic o_wr_stb,
  output logic [7:0] o_wr_byte,
  output logic o_rd_stb
);
  initial
  begin
    o_reg_index = 2'h0;
    o_xfer_start = 1'b0;
    o_wr_stb = 1'b0;
    o_wr_byte = 8'hA5;
    o_rd_stb = 1'b0;
  end

  // Index is set with the start pulse and held through the transfer
  task automatic open_xfer(input logic [1:0] idx);
    @(posedge i_clk);
    o_reg_index <= idx;
    o_xfer_start <= 1'b1;
    @(posedge i_clk);
    o_xfer_start <= 1'b0;
  endtask

  // High byte first, then low byte
  task automatic write_word(input logic [1:0] idx, input logic [15:0] v);
    open_xfer(idx);
    o_wr_stb <= 1'b1;
    o_wr_byte <= v[15:8];
    @(posedge i_clk);
    o_wr_byte <= v[7:0];
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    o_wr_byte <= ~v[7:0];
    @(posedge i_clk);
    #1;
  endtask

  // Two read strobes back to back, high byte returned first
  task automatic read_word(input logic [1:0] idx, output logic [15:0] v);
    open_xfer(idx);
    o_rd_stb <= 1'b1;
    @(posedge i_clk);
    #1;
    v[15:8] = i_rd_byte;
    @(posedge i_clk);
    o_rd_stb <= 1'b0;
    #1;
    v[7:0] = i_rd_byte;
  endtask
endmodule
